// ===== src/sdc_cfg.svh
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH

// Register byte offsets
`define SDC_CTRL_OFS 4'h0
`define SDC_STAT_OFS 4'h4

// Control register fields
`define SDC_CTRL_IN_BIT 0
`define SDC_CTRL_PIPE_BIT 1
`define SDC_CTRL_OUT_BIT 2
`define SDC_CTRL_ALGO_BIT 3
`define SDC_CTRL_W 4
`define SDC_CTRL_RST 4'h8

// Status register fields
`define SDC_STAT_SBIT_LSB 0
`define SDC_STAT_DBIT_LSB 16
`define SDC_CNT_W 16
`define SDC_STAT_RST 16'h0000

// Supported data widths
`define SDC_MIN_W 4
`define SDC_HAM_MAX_W 64
`define SDC_HSI_MAX_W 128

`endif

// ===== src/sdc_pkg.sv
package sdc_pkg;

  typedef enum logic [1:0] {SDC_ENC_ONLY, SDC_DEC_ONLY, SDC_ENC_DEC} sdc_mode_type;
  typedef enum logic {SDC_BUS_IDLE, SDC_BUS_ANSWER} sdc_bus_state_type;

  function automatic int sdc_ones(input int v);
    int n;
    n = 0;
    for (int b = 0; b < 16; b++) begin
      n = n + ((v >> b) & 1);
    end
    return n;
  endfunction : sdc_ones

  // Hamming: r position bits plus one overall parity bit
  function automatic int sdc_ham_r(input int k);
    for (int r = 2; r < 10; r++) begin
      if ((1 << r) >= k + r + 1) return r;
    end
    return 10;
  endfunction : sdc_ham_r

  // Hsiao: smallest r giving enough odd-weight columns of weight three or more
  function automatic int sdc_hsi_r(input int k);
    int total;
    for (int r = 4; r < 10; r++) begin
      total = 0;
      for (int v = 0; v < (1 << r); v++) begin
        if (sdc_ones(v) >= 3 && sdc_ones(v) % 2 == 1) total++;
      end
      if (total >= k) return r;
    end
    return 9;
  endfunction : sdc_hsi_r

  function automatic int sdc_chk_w(input int k);
    int ham;
    int hsi;
    ham = (k <= 64) ? sdc_ham_r(k) + 1 : 0;
    hsi = sdc_hsi_r(k);
    return (ham > hsi) ? ham : hsi;
  endfunction : sdc_chk_w

  // Extended Hamming column: position code, overall bit set to make weight odd
  function automatic int sdc_col_ham(input int i, input int r);
    int n;
    n = 0;
    for (int p = 3; p < 256; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (n == i) return (sdc_ones(p) % 2 == 1) ? p : (p | (1 << r));
        n++;
      end
    end
    return 0;
  endfunction : sdc_col_ham

  function automatic int sdc_col_hsi(input int i, input int r);
    int n;
    n = 0;
    for (int w = 3; w < 10; w = w + 2) begin
      for (int v = 0; v < (1 << r); v++) begin
        if (sdc_ones(v) == w) begin
          if (n == i) return v;
          n++;
        end
      end
    end
    return 0;
  endfunction : sdc_col_hsi

endpackage : sdc_pkg

// ===== src/sdc_stage.sv
`timescale 1ns/1ps
`default_nettype none

module sdc_stage #(
  parameter int W = 8
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_sync_reset,
  input wire logic i_clken,
  input wire logic i_enable,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  always_comb begin
    q_nxt = q_r;
    if (i_sync_reset) begin
      q_nxt = '0;
    end else if (i_clken) begin
      q_nxt = i_d;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Omitted stage is a plain wire
  assign o_q = i_enable ? q_r : i_d;

endmodule : sdc_stage

`default_nettype wire

// ===== src/sdc_codec.sv
// What this block does
// - Hamming code accepts data widths from 4 to 64 bits.
// - Hsiao code accepts data widths from 4 to 128 bits.
// - Built as encoder only, decoder only or combined, chosen at build time.
// - Encoding computes 4 to 9 check bits, count set by data width.
// - Encoding outputs the unchanged data together with its check bits.
// - Decoding forms a syndrome, corrects one flipped data bit, raises single flag.
// - Double error leaves data uncorrected and raises the double flag.
// - No error passes data unchanged with both flags low.
// - Correction-disable high in decode forwards data with both flags low.
// - Combined build encodes while encode-select high, decodes while low.
// - Combined build honours correction-disable during decode as a bypass.
// - Input, pipeline and output stages each enabled independently.
// - Pipeline stage splits the code logic into two halves.
// - Stages advance only on edges with clock enable high.
// - Stages cleared by a synchronous active-high reset.
// - More than two errors may be misreported or miscorrected.
// - Each enabled stage adds exactly one cycle of latency.
// - Check output carries check bits when encoding, syndrome when decoding.
// - Combined build ignores check inputs and correction-disable while encoding.
`timescale 1ns/1ps
`default_nettype none
`include "sdc_cfg.svh"

module sdc_codec
  import sdc_pkg::*;
#(
  parameter int DATA_W = 64,
  parameter sdc_mode_type MODE = SDC_ENC_DEC,
  localparam int CHK_W = sdc_chk_w(DATA_W)
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_ecc_clken,
  input wire logic i_ecc_reset,
  input wire logic [DATA_W-1:0] i_data,
  input wire logic [CHK_W-1:0] i_chk,
  input wire logic i_correct_n,
  input wire logic i_encode,
  output logic [DATA_W-1:0] o_data,
  output logic [CHK_W-1:0] o_chk,
  output logic o_sbit_err,
  output logic o_dbit_err,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);

  localparam int SW = DATA_W + CHK_W + 2;
  localparam int HAM_R = sdc_ham_r(DATA_W);
  localparam int HSI_R = sdc_hsi_r(DATA_W);

  // Widths outside the supported range stop elaboration
  if (DATA_W < `SDC_MIN_W || DATA_W > `SDC_HSI_MAX_W) begin : g_bad_width
    $error("data width out of range");
  end

  logic [`SDC_CTRL_W-1:0] ctrl_r;
  logic [`SDC_CTRL_W-1:0] ctrl_nxt;
  logic [`SDC_CNT_W-1:0] sbit_cnt_r;
  logic [`SDC_CNT_W-1:0] sbit_cnt_nxt;
  logic [`SDC_CNT_W-1:0] dbit_cnt_r;
  logic [`SDC_CNT_W-1:0] dbit_cnt_nxt;
  sdc_bus_state_type bus_state_r;
  sdc_bus_state_type bus_state_nxt;
  logic [31:0] readdata_r;
  logic [31:0] readdata_nxt;
  logic waitrequest_r;
  logic waitrequest_nxt;

  logic use_hsiao;
  logic [CHK_W-1:0] col [DATA_W];
  logic [SW-1:0] in_q;
  logic [SW-1:0] pipe_d;
  logic [SW-1:0] pipe_q;
  logic [SW-1:0] out_d;
  logic [SW-1:0] out_q;
  logic [DATA_W-1:0] a_data;
  logic [CHK_W-1:0] a_chk;
  logic a_enc;
  logic a_cn;
  logic [CHK_W-1:0] a_calc;
  logic [DATA_W-1:0] b_data;
  logic [CHK_W-1:0] b_syn;
  logic b_enc;
  logic b_cn;
  logic [DATA_W-1:0] b_flip;
  logic b_sbit;
  logic b_dbit;

  // Hamming runs out of columns above 64 bits, so wider words use Hsiao
  assign use_hsiao = (DATA_W > `SDC_HAM_MAX_W) ? 1'b1 : ctrl_r[`SDC_CTRL_ALGO_BIT];

  // Every column has odd weight, so syndrome parity tells single from double
  always_comb begin
    for (int i = 0; i < DATA_W; i++) begin
      col[i] = use_hsiao ? CHK_W'(sdc_col_hsi(i, HSI_R)) : CHK_W'(sdc_col_ham(i, HAM_R));
    end
  end

  sdc_stage #(.W(SW)) u_in_stage (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_sync_reset(i_ecc_reset),
    .i_clken(i_ecc_clken),
    .i_enable(ctrl_r[`SDC_CTRL_IN_BIT]),
    .i_d({i_data, i_chk, i_encode, i_correct_n}),
    .o_q(in_q)
  );

  // First half: check bits or syndrome
  always_comb begin
    a_data = in_q[SW-1 -: DATA_W];
    a_chk = in_q[CHK_W+1:2];
    a_cn = in_q[0];
    if (MODE == SDC_ENC_ONLY) begin
      a_enc = 1'b1;
    end else if (MODE == SDC_DEC_ONLY) begin
      a_enc = 1'b0;
    end else begin
      a_enc = in_q[1];
    end
    a_calc = '0;
    for (int i = 0; i < DATA_W; i++) begin
      if (a_data[i]) begin
        a_calc = a_calc ^ col[i];
      end
    end
    // Check inputs only matter when decoding
    pipe_d = {a_data, a_enc ? a_calc : (a_calc ^ a_chk), a_enc, a_cn};
  end

  sdc_stage #(.W(SW)) u_pipe_stage (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_sync_reset(i_ecc_reset),
    .i_clken(i_ecc_clken),
    .i_enable(ctrl_r[`SDC_CTRL_PIPE_BIT]),
    .i_d(pipe_d),
    .o_q(pipe_q)
  );

  // Second half: classify and correct
  always_comb begin
    b_data = pipe_q[SW-1 -: DATA_W];
    b_syn = pipe_q[CHK_W+1:2];
    b_enc = pipe_q[1];
    b_cn = pipe_q[0];
    b_sbit = 1'b0;
    b_dbit = 1'b0;
    b_flip = '0;
    if (!b_enc && !b_cn && b_syn != '0) begin
      // Three or more errors can alias a single error here
      b_sbit = ^b_syn;
      b_dbit = ~^b_syn;
      for (int i = 0; i < DATA_W; i++) begin
        b_flip[i] = b_sbit && (b_syn == col[i]);
      end
    end
    out_d = {b_data ^ b_flip, b_syn, b_sbit, b_dbit};
  end

  sdc_stage #(.W(SW)) u_out_stage (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_sync_reset(i_ecc_reset),
    .i_clken(i_ecc_clken),
    .i_enable(ctrl_r[`SDC_CTRL_OUT_BIT]),
    .i_d(out_d),
    .o_q(out_q)
  );

  // Unregistered path when stages are off, by design
  assign o_data = out_q[SW-1 -: DATA_W];
  assign o_chk = out_q[CHK_W+1:2];
  assign o_sbit_err = out_q[1];
  assign o_dbit_err = out_q[0];

  // Register slave: one wait cycle, write lands on the answering edge
  always_comb begin
    bus_state_nxt = bus_state_r;
    waitrequest_nxt = 1'b1;
    readdata_nxt = readdata_r;
    ctrl_nxt = ctrl_r;
    sbit_cnt_nxt = sbit_cnt_r;
    dbit_cnt_nxt = dbit_cnt_r;
    case (bus_state_r)
      SDC_BUS_IDLE: begin
        if (i_avs_read || i_avs_write) begin
          bus_state_nxt = SDC_BUS_ANSWER;
          waitrequest_nxt = 1'b0;
          if (i_avs_address == `SDC_CTRL_OFS) begin
            readdata_nxt = {{(32-`SDC_CTRL_W){1'b0}}, ctrl_r};
          end else if (i_avs_address == `SDC_STAT_OFS) begin
            readdata_nxt = {dbit_cnt_r, sbit_cnt_r};
          end else begin
            readdata_nxt = 32'h0000_0000;
          end
        end
      end
      SDC_BUS_ANSWER: begin
        bus_state_nxt = SDC_BUS_IDLE;
        if (i_avs_write && i_avs_byteenable[0] && i_avs_address == `SDC_CTRL_OFS) begin
          ctrl_nxt = i_avs_writedata[`SDC_CTRL_W-1:0];
        end else if (i_avs_write && i_avs_address == `SDC_STAT_OFS) begin
          sbit_cnt_nxt = `SDC_STAT_RST;
          dbit_cnt_nxt = `SDC_STAT_RST;
        end
      end
      default: begin
        bus_state_nxt = SDC_BUS_IDLE;
      end
    endcase
    // Event counting after a clear so a same-cycle event survives
    if (i_ecc_clken && o_sbit_err && sbit_cnt_nxt != '1) begin
      sbit_cnt_nxt = sbit_cnt_nxt + 1'b1;
    end
    if (i_ecc_clken && o_dbit_err && dbit_cnt_nxt != '1) begin
      dbit_cnt_nxt = dbit_cnt_nxt + 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bus_state_r <= SDC_BUS_IDLE;
      waitrequest_r <= 1'b1;
      readdata_r <= 32'h0000_0000;
      ctrl_r <= `SDC_CTRL_RST;
      sbit_cnt_r <= `SDC_STAT_RST;
      dbit_cnt_r <= `SDC_STAT_RST;
    end else begin
      bus_state_r <= bus_state_nxt;
      waitrequest_r <= waitrequest_nxt;
      readdata_r <= readdata_nxt;
      ctrl_r <= ctrl_nxt;
      sbit_cnt_r <= sbit_cnt_nxt;
      dbit_cnt_r <= dbit_cnt_nxt;
    end
  end

  assign o_avs_readdata = readdata_r;
  assign o_avs_waitrequest = waitrequest_r;

  // Helper views for the checks below
  logic all_off;
  logic in_only;
  logic out_off;
  assign all_off = (ctrl_r[2:0] == 3'h0);
  assign in_only = (ctrl_r[2:0] == 3'h1);
  assign out_off = !ctrl_r[`SDC_CTRL_OUT_BIT];

  property p_flags_exclusive;
    @(posedge i_clock) disable iff (!i_reset_n)
    !(o_sbit_err && o_dbit_err);
  endproperty
  a_flags_exclusive: assert property (p_flags_exclusive)
    else $error("single and double error flags high together");

  property p_bypass;
    @(posedge i_clock) disable iff (!i_reset_n)
    (all_off && MODE != SDC_ENC_ONLY && !a_enc && i_correct_n)
      |-> (o_data == i_data && !o_sbit_err && !o_dbit_err);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("correction bypass altered data or raised a flag");

  property p_clean_word;
    @(posedge i_clock) disable iff (!i_reset_n)
    (out_off && !b_enc && b_syn == '0) |-> (o_data == b_data && !o_sbit_err && !o_dbit_err);
  endproperty
  a_clean_word: assert property (p_clean_word)
    else $error("clean word was changed or flagged");

  property p_double_kept;
    @(posedge i_clock) disable iff (!i_reset_n)
    (out_off && !b_enc && !b_cn && b_syn != '0 && !(^b_syn)) |-> (o_data == b_data && o_dbit_err);
  endproperty
  a_double_kept: assert property (p_double_kept)
    else $error("double error was corrected or not flagged");

  property p_encode_word;
    @(posedge i_clock) disable iff (!i_reset_n)
    (all_off && a_enc) |-> (o_data == i_data && o_chk == a_calc && !o_sbit_err && !o_dbit_err);
  endproperty
  a_encode_word: assert property (p_encode_word)
    else $error("encoded codeword does not carry the input data");

  property p_one_cycle;
    @(posedge i_clock) disable iff (!i_reset_n)
    (in_only && i_ecc_clken && !i_ecc_reset) ##1 (in_only && a_enc) |-> (o_data == $past(i_data));
  endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("input stage latency is not one cycle");

  property p_clken_hold;
    @(posedge i_clock) disable iff (!i_reset_n)
    (in_only && !i_ecc_clken && !i_ecc_reset) ##1 in_only |-> $stable(o_data);
  endproperty
  a_clken_hold: assert property (p_clken_hold)
    else $error("stage moved without clock enable");

  property p_sync_clear;
    @(posedge i_clock) disable iff (!i_reset_n)
    (ctrl_r[2:0] == 3'h7 && i_ecc_reset) ##1 (ctrl_r[2:0] == 3'h7)
      |-> (o_data == '0 && o_chk == '0 && !o_sbit_err && !o_dbit_err);
  endproperty
  a_sync_clear: assert property (p_sync_clear)
    else $error("synchronous reset did not clear the output stage");

  property p_bus_answer;
    @(posedge i_clock) disable iff (!i_reset_n)
    (bus_state_r == SDC_BUS_IDLE && (i_avs_read || i_avs_write)) |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("register access not answered after one wait cycle");

endmodule : sdc_codec

`default_nettype wire

// ===== bench/sdc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module sdc_mem_model #(
  parameter int WORD_W = 72
) (
  input wire logic i_clock,
  input wire logic i_we,
  input wire logic [3:0] i_addr,
  input wire logic [WORD_W-1:0] i_wdata,
  input wire logic [WORD_W-1:0] i_flip,
  output logic [WORD_W-1:0] o_rdata
);
  // Stored codewords; the flip mask models upsets on the read path
  logic [WORD_W-1:0] store_r [16];

  always_ff @(posedge i_clock) begin
    if (i_we) begin
      store_r[i_addr] <= i_wdata;
    end
  end

  assign o_rdata = store_r[i_addr] ^ i_flip;
endmodule : sdc_mem_model

`default_nettype wire

// ===== bench/sdc_codec_test.sv
`timescale 1ns/1ps
`default_nettype none
`define SDC_CMP(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end

module sdc_codec_test;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic clken = 1'b1, srst = 1'b0, enc = 1'b1, corr_n = 1'b0, we = 1'b0;
  logic av_rd = 1'b0, av_wr = 1'b0, o_wait, sbit, dbit;
  logic [3:0] addr = 4'h0, av_a = 4'h0, av_be = 4'hf;
  logic [31:0] av_wd = 32'h0, rd, o_rdata;
  logic [71:0] wd = 72'h0, flip = 72'h0, mem_q;
  logic [63:0] o_data;
  logic [7:0] o_chk;
  int n_fail = 0, check_count = 0, lat = 0;

  initial begin
    forever #50 i_clock = ~i_clock;
  end

  sdc_mem_model #(.WORD_W(72)) u_mem (.i_clock(i_clock), .i_we(we), .i_addr(addr), .i_wdata(wd),
    .i_flip(flip), .o_rdata(mem_q));

  sdc_codec u_dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_ecc_clken(clken), .i_ecc_reset(srst),
    .i_data(mem_q[63:0]), .i_chk(mem_q[71:64]), .i_correct_n(corr_n), .i_encode(enc),
    .o_data(o_data), .o_chk(o_chk), .o_sbit_err(sbit), .o_dbit_err(dbit), .i_avs_address(av_a),
    .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wd), .i_avs_byteenable(av_be),
    .o_avs_readdata(o_rdata), .o_avs_waitrequest(o_wait));

  // Request held until the edge that sees waitrequest low; no fixed answer time assumed
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge i_clock);
    av_rd <= !w;
    av_wr <= w;
    av_a <= a;
    av_wd <= v;
    av_be <= be;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_wait !== 1'b0 && n < 50);
    if (n >= 50) n_fail++;
    rd = o_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask : bus

  // Store a word, then wait out the configured stage latency
  task automatic apply(input logic e, input logic cn, input logic [71:0] w, input logic [71:0] f);
    @(posedge i_clock);
    we <= 1'b1;
    addr <= 4'($urandom_range(15));
    wd <= w;
    flip <= f;
    enc <= e;
    corr_n <= cn;
    @(posedge i_clock);
    we <= 1'b0;
    repeat (lat) @(posedge i_clock);
    @(negedge i_clock);
  endtask : apply

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge i_clock);
    n_fail++;
    wrap_up();
  end

  initial begin
    logic [63:0] d;
    logic [7:0] c;
    logic [71:0] m;
    int b, j, k2;
    void'($urandom(32'h43f6));
    repeat (6) @(posedge i_clock);
    i_reset_n <= 1'b1;
    bus(1'b0, 4'h0, 32'h0, 4'hf);
    `SDC_CMP("ctrl reset", 32'h8, rd)
    bus(1'b0, 4'h4, 32'h0, 4'hf);
    `SDC_CMP("stat reset", 32'h0, rd)
    bus(1'b1, 4'h8, 32'hffff_ffff, 4'hf);
    bus(1'b0, 4'h8, 32'h0, 4'hf);
    `SDC_CMP("unmapped", 32'h0, rd)
    bus(1'b1, 4'h0, 32'h7, 4'he);
    bus(1'b0, 4'h0, 32'h0, 4'hf);
    `SDC_CMP("ctrl no lane", 32'h8, rd)
    $display("test bus done");
    // Every stage mix under both codes; zero stages is the combinational case
    for (int cfg = 0; cfg < 16; cfg++) begin
      bus(1'b1, 4'h0, 32'(cfg), 4'hf);
      lat = $countones(cfg[2:0]);
      for (int k = 0; k < 6; k++) begin
        d = {$urandom, $urandom};
        b = $urandom_range(63);
        j = (b + 1 + $urandom_range(62)) % 64;
        k2 = $urandom_range(7);
        apply(1'b1, 1'b0, {8'($urandom), d}, 72'h0);
        `SDC_CMP("enc data", d, o_data)
        `SDC_CMP("enc flags", 2'b00, {sbit, dbit})
        c = o_chk;
        apply(1'b1, 1'b1, {~c, d}, 72'h0);
        `SDC_CMP("enc chk", c, o_chk)
        apply(1'b0, 1'b0, {c, d}, 72'h0);
        `SDC_CMP("clean data", d, o_data)
        `SDC_CMP("clean syn", 8'h0, o_chk)
        `SDC_CMP("clean flags", 2'b00, {sbit, dbit})
        apply(1'b0, 1'b0, {c, d}, 72'h1 << b);
        `SDC_CMP("fix data", d, o_data)
        `SDC_CMP("fix flags", 2'b10, {sbit, dbit})
        apply(1'b0, 1'b0, {c, d}, 72'h1 << (64 + k2));
        `SDC_CMP("chk syn", 8'(1 << k2), o_chk)
        `SDC_CMP("chk data", d, o_data)
        m = (72'h1 << b) | (72'h1 << j);
        apply(1'b0, 1'b0, {c, d}, m);
        `SDC_CMP("dbl data", d ^ m[63:0], o_data)
        `SDC_CMP("dbl flags", 2'b01, {sbit, dbit})
        apply(1'b0, 1'b1, {c, d}, 72'h1 << b);
        `SDC_CMP("byp data", d ^ (64'h1 << b), o_data)
        `SDC_CMP("byp flags", 2'b00, {sbit, dbit})
      end
      $display("test config %0d done", cfg);
    end
    // All three stages on: hold while clken low, then exactly three loads
    d = {$urandom, $urandom};
    apply(1'b1, 1'b0, {8'h0, d}, 72'h0);
    @(posedge i_clock);
    clken <= 1'b0;
    we <= 1'b1;
    wd <= {8'h0, ~d};
    @(posedge i_clock);
    we <= 1'b0;
    repeat (4) @(posedge i_clock);
    @(negedge i_clock);
    `SDC_CMP("hold", d, o_data)
    @(posedge i_clock);
    clken <= 1'b1;
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
    `SDC_CMP("lat early", d, o_data)
    @(negedge i_clock);
    `SDC_CMP("lat due", ~d, o_data)
    // Sync reset must clear stages even with clken low
    @(posedge i_clock);
    clken <= 1'b0;
    srst <= 1'b1;
    @(posedge i_clock);
    srst <= 1'b0;
    @(negedge i_clock);
    `SDC_CMP("srst out", 74'h0, {o_data, o_chk, sbit, dbit})
    @(posedge i_clock);
    clken <= 1'b1;
    bus(1'b0, 4'h4, 32'h0, 4'hf);
    `SDC_CMP("stat sbit seen", 1'b1, rd[15:0] != 16'h0)
    `SDC_CMP("stat dbit seen", 1'b1, rd[31:16] != 16'h0)
    bus(1'b1, 4'h4, 32'h0, 4'hf);
    bus(1'b0, 4'h4, 32'h0, 4'hf);
    `SDC_CMP("stat clear", 32'h0, rd)
    $display("test stages done");
    wrap_up();
  end
endmodule : sdc_codec_test

`default_nettype wire
